// >>> bench/dac_test_decode_power_regs_asserts.sv
// Purpose: Port-level checks for the test, decode and power register group
// Assumes: Control outputs follow a register write two edges after the strobe
// Notes:   Bound into every instance of the register group
module dac_test_decode_power_regs_asserts (
	input wire logic                              I_CORE_CLK,     // Core clock
	input wire logic                              I_RST_N,        // Async reset, active low
	input wire logic                              i_reg_wr,       // Write strobe
	input wire logic                              i_reg_rd,       // Read strobe
	input wire logic [11:0]                       i_reg_addr,     // Offset
	input wire logic [7:0]                        i_reg_wdata,    // Write data
	input wire logic [7:0]                        o_reg_rdata,    // Read data
	input wire logic                              i_sample_valid, // Sample strobe
	input wire logic [15:0]                       i_sample_real,  // Real sample
	input wire logic [15:0]                       i_sample_imag,  // Imaginary sample
	input wire logic [15:0]                       o_dac_word,     // Converter word
	input wire dac_test_decode_power_pkg::shuffle_t    o_shuffle,      // Shuffle selects
	input wire dac_test_decode_power_pkg::out_format_t o_out_format,   // Output format
	input wire dac_test_decode_power_pkg::port_drive_t o_port_drive,   // Port drive
	input wire logic                              o_receiver_off, // Receiver off
	input wire logic [7:0]                        o_lane_off      // Lane off mask
);
	import dac_test_decode_power_pkg::*;
	// ****************************************************************
	// Write-to-output and read relations
	// ****************************************************************
	default clocking @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_RST_N);
	shuffle_follow_a: assert property (i_reg_wr && i_reg_addr == ADDR_SHUFFLE_CONTROL |->
		##2 o_shuffle == $past(i_reg_wdata[2:0], 2)) else $error("Shuffle select mismatch");
	format_follow_a: assert property (i_reg_wr && i_reg_addr == ADDR_FORMAT_SELECT |->
		##2 o_out_format == $past(i_reg_wdata[1:0], 2)) else $error("Output format mismatch");
	drive_follow_a: assert property (i_reg_wr && i_reg_addr == ADDR_PORT_DRIVE |->
		##2 o_port_drive == $past(i_reg_wdata[3:0], 2)) else $error("Port drive mismatch");
	master_follow_a: assert property (i_reg_wr && i_reg_addr == ADDR_MASTER_POWERDOWN |->
		##2 o_receiver_off == $past(i_reg_wdata[0], 2)) else $error("Receiver off mismatch");
	master_lanes_a: assert property (o_receiver_off |-> o_lane_off == 8'hff)
		else $error("Lanes awake while receiver off");
	lane_follow_a: assert property (i_reg_wr && i_reg_addr == ADDR_LANE_POWERDOWN ##2 !o_receiver_off |->
		o_lane_off == $past(i_reg_wdata, 2)) else $error("Lane mask mismatch");
	const_readback_a: assert property (i_reg_wr && i_reg_addr == ADDR_CONST_VALUE_HIGH ##2
		i_reg_rd && i_reg_addr == ADDR_CONST_VALUE_HIGH |=> o_reg_rdata == $past(i_reg_wdata, 3))
		else $error("Constant byte readback mismatch");
	rdata_hold_a: assert property (!i_reg_rd |=> $stable(o_reg_rdata)) else $error("Read data moved");
endmodule
bind dac_test_decode_power_regs dac_test_decode_power_regs_asserts chk (.I_CORE_CLK(I_CORE_CLK),
	.I_RST_N(I_RST_N), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
	.i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .i_sample_valid(i_sample_valid),
	.i_sample_real(i_sample_real), .i_sample_imag(i_sample_imag), .o_dac_word(o_dac_word),
	.o_shuffle(o_shuffle), .o_out_format(o_out_format), .o_port_drive(o_port_drive),
	.o_receiver_off(o_receiver_off), .o_lane_off(o_lane_off));

// >>> bench/tb_top.sv
// Purpose: Register-level bench for the test, decode and power register group
// Assumes: Inputs change on the falling edge; read data sampled one cycle on
// Notes:   Sequence checker fed with a self-made recurrence on sample bit 0
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import dac_test_decode_power_pkg::*;
	// ****************************************************************
	// Signals, tables and instance
	// ****************************************************************
	logic        clk = 0, rst_n = 0, wr = 0, rd = 0, valid = 0; // Bench-driven controls
	logic [11:0] addr = '0;                                    // Register offset
	logic [7:0]  wdata = '0, rdata, loff;                      // Data and lane mask
	logic [15:0] sreal = '0, simag = '0, dac;                  // Samples and converter word
	logic [14:0] gen = 15'h7fff;                               // Sequence generator state
	shuffle_t    shuf;                                         // Shuffle selects
	out_format_t fmt;                                          // Output format
	port_drive_t drv;                                          // Port drive
	logic        roff;                                         // Receiver off
	int          n_errors = 0, n_tests = 0;                    // Tallies
	logic [11:0] offs [12] = '{12'h14b, 12'h14c, 12'h14d, 12'h14e, 12'h14f, 12'h150, 12'h151, 12'h152,
		12'h1df, 12'h200, 12'h201, 12'h300};                   // Mapped offsets plus one unmapped
	logic [7:0]  rst_v [12] = '{8'h10, 0, 0, 0, 0, 0, 0, 0, 8'h0f, 8'h01, 0, 0}; // Reset values
	logic [7:0]  ff_v [12] = '{8'h1f, 0, 0, 8'hff, 8'hff, 8'h02, 8'h07, 8'h03, 8'h0f, 8'h01, 8'hff, 0}; // After 0xff
	dac_test_decode_power_regs #(.LANES(8)) uut (.I_CORE_CLK(clk), .I_RST_N(rst_n), .i_reg_wr(wr),
		.i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_sample_valid(valid),
		.i_sample_real(sreal), .i_sample_imag(simag), .o_dac_word(dac), .o_shuffle(shuf),
		.o_out_format(fmt), .o_port_drive(drv), .o_receiver_off(roff), .o_lane_off(loff));
	// Free-running core clock
	initial forever #5 clk = ~clk;
	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
		@(negedge clk); wr = 1; addr = a; wdata = d;
		@(negedge clk); wr = 0;
	endtask
	task automatic chk_reg(input logic [11:0] a, input logic [7:0] exp);
		@(negedge clk); rd = 1; addr = a;
		@(negedge clk); rd = 0;
		cmp(rdata, exp);
	endtask
	// Feed n sequence bits, real bit inverted at index flip
	task automatic prbs(input int n, input bit long_poly, input int flip);
		logic b;
		for (int k = 0; k < n; k++) begin
			b = long_poly ? gen[14] ^ gen[13] : gen[6] ^ gen[5];
			gen = {gen[13:0], b};
			@(negedge clk); valid = 1; sreal[0] = b ^ (k == flip); simag[0] = b;
		end
		@(negedge clk); valid = 0;
	endtask
	task automatic complete_run();
		$display("Counts: errors %0d tests %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// ****************************************************************
	// Main sequence and watchdog
	// ****************************************************************
	initial begin
		repeat (3) @(negedge clk);
		rst_n = 1;
		cmp(drv, 16'hf);
		cmp({roff, loff}, 16'h1ff);
		for (int i = 0; i < 12; i++) chk_reg(offs[i], rst_v[i]);
		for (int i = 0; i < 12; i++) begin
			wr_reg(offs[i], 8'hff);
			chk_reg(offs[i], ff_v[i]);
		end
		for (int f = 0; f < 3; f++) begin
			wr_reg(ADDR_FORMAT_SELECT, f[7:0]); @(negedge clk);
			cmp(fmt, f[15:0]);
		end
		for (int s = 0; s < 3; s++) begin
			wr_reg(ADDR_SHUFFLE_CONTROL, 8'h1 << s); @(negedge clk);
			cmp(shuf, 16'h1 << s);
		end
		wr_reg(ADDR_PORT_DRIVE, 8'h06); @(negedge clk);
		cmp(drv.slew, 16'h2);
		cmp(drv.strength, 16'h1);
		wr_reg(ADDR_MASTER_POWERDOWN, 8'h00); wr_reg(ADDR_LANE_POWERDOWN, 8'h5a); @(negedge clk);
		cmp({roff, loff}, 16'h05a);
		wr_reg(ADDR_MASTER_POWERDOWN, 8'h01); @(negedge clk);
		cmp({roff, loff}, 16'h1ff);
		wr_reg(ADDR_CONST_VALUE_HIGH, 8'ha5); wr_reg(ADDR_CONST_VALUE_LOW, 8'h3c); wr_reg(ADDR_DIGITAL_TEST, 8'h02);
		@(negedge clk); cmp(dac, 16'ha53c);
		wr_reg(ADDR_DIGITAL_TEST, 8'h00); sreal = 16'h1234; repeat (2) @(negedge clk);
		cmp(dac, 16'h1234);
		wr_reg(ADDR_SEQ_CHECK_CONTROL, 8'h01); prbs(40, 0, 20);
		chk_reg(ADDR_SEQ_ERRORS_REAL, 8'h03);
		chk_reg(ADDR_SEQ_ERRORS_IMAG, 8'h00);
		chk_reg(ADDR_SEQ_CHECK_CONTROL, 8'hc1);
		wr_reg(ADDR_SEQ_CHECK_CONTROL, 8'h03);
		chk_reg(ADDR_SEQ_ERRORS_REAL, 8'h00);
		wr_reg(ADDR_SEQ_CHECK_CONTROL, 8'h05); prbs(60, 1, 40);
		chk_reg(ADDR_SEQ_ERRORS_REAL, 8'h03);
		chk_reg(ADDR_SEQ_CHECK_CONTROL, 8'hc5);
		prbs(16, 1, 15);
		chk_reg(ADDR_SEQ_CHECK_CONTROL, 8'h85);
		chk_reg(ADDR_SEQ_ERRORS_REAL, 8'h04);
		wr_reg(ADDR_SEQ_CHECK_CONTROL, 8'h04); prbs(20, 1, 5);
		chk_reg(ADDR_SEQ_CHECK_CONTROL, 8'h04);
		chk_reg(ADDR_SEQ_ERRORS_REAL, 8'h04);
		complete_run();
	end
	// Cuts a hang short
	initial begin
		#500us;
		n_errors++;
		complete_run();
	end
endmodule

// >>> rtl/dac_test_decode_power_pkg.sv
// Purpose: Constants and types for the converter test, decode and power register group
// Assumes: Byte-wide registers reached through the configuration serial port core
// Notes:   All offsets, field positions and reset values live here, except the constant test enable and error counters, which the register file resets to 0
package dac_test_decode_power_pkg;

	// ****************************************************************
	// Register offsets
	// ****************************************************************
	localparam logic [11:0] ADDR_SEQ_CHECK_CONTROL   = 12'h14b; // Checker control and good flags
	localparam logic [11:0] ADDR_SEQ_ERRORS_REAL     = 12'h14c; // Real channel error count
	localparam logic [11:0] ADDR_SEQ_ERRORS_IMAG     = 12'h14d; // Imaginary channel error count
	localparam logic [11:0] ADDR_CONST_VALUE_HIGH    = 12'h14e; // Constant word high byte
	localparam logic [11:0] ADDR_CONST_VALUE_LOW     = 12'h14f; // Constant word low byte
	localparam logic [11:0] ADDR_DIGITAL_TEST        = 12'h150; // Constant test enable
	localparam logic [11:0] ADDR_SHUFFLE_CONTROL     = 12'h151; // Segment shuffle bits
	localparam logic [11:0] ADDR_FORMAT_SELECT       = 12'h152; // Output format field
	localparam logic [11:0] ADDR_PORT_DRIVE          = 12'h1df; // Config port drive field
	localparam logic [11:0] ADDR_MASTER_POWERDOWN    = 12'h200; // Receiver master off
	localparam logic [11:0] ADDR_LANE_POWERDOWN      = 12'h201; // Per-lane off mask

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int BIT_SEQ_ON        = 0; // Checker enable
	localparam int BIT_SEQ_CLEAR     = 1; // Error counter clear
	localparam int BIT_SEQ_POLY      = 2; // Polynomial select
	localparam int BIT_SEQ_INV_REAL  = 3; // Expect inverted real data
	localparam int BIT_SEQ_INV_IMAG  = 4; // Expect inverted imaginary data
	localparam int BIT_SEQ_GOOD_REAL = 6; // Real good flag
	localparam int BIT_SEQ_GOOD_IMAG = 7; // Imaginary good flag
	localparam int BIT_CONST_ON      = 1; // Constant test enable
	localparam int BIT_SHUF_FAST     = 0; // Double-rate path shuffle
	localparam int BIT_SHUF_MIDDLE   = 1; // Middle segment shuffle
	localparam int BIT_SHUF_TOP      = 2; // Top segment shuffle
	localparam int BIT_MASTER_OFF    = 0; // Receiver master off

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [4:0] RST_SEQ_CONTROL = 5'h10; // Imaginary inversion set
	localparam logic [7:0] RST_CONST_BYTE  = 8'h00; // Constant bytes clear
	localparam logic [2:0] RST_SHUFFLE     = 3'h0;  // Thermometer everywhere
	localparam logic [1:0] RST_FORMAT      = 2'h0;  // First-zone NRZ
	localparam logic [3:0] RST_PORT_DRIVE  = 4'hf;  // Full slew and strength
	localparam logic       RST_MASTER_OFF  = 1'b1;  // Receiver off at start
	localparam logic [7:0] RST_LANE_MASK   = 8'h00; // No lane forced off

	// ****************************************************************
	// Sequence checker sizes
	// ****************************************************************
	localparam int SHORT_SEQ_LEN = 7;  // Short sequence order
	localparam int LONG_SEQ_LEN  = 15; // Long sequence order

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [1:0] {
		FORMAT_NRZ,   // First-zone nonreturn-to-zero
		FORMAT_MIX,   // Mixing output
		FORMAT_RZ,    // Return-to-zero
		FORMAT_RSVD   // Reserved, not to be programmed
	} out_format_t;

	typedef struct packed {
		logic top_segment_scramble;    // Top segments shuffled
		logic middle_segment_scramble; // Middle segments shuffled
		logic fast_path_scramble;      // Double-rate path shuffled
	} shuffle_t;

	typedef struct packed {
		logic [1:0] strength; // Drive strength
		logic [1:0] slew;     // Slew rate
	} port_drive_t;

endpackage

// >>> rtl/dac_test_decode_power_regs.sv
// Purpose: Test, decode and power register group with sequence checker and constant test
// Assumes: Register strobes come from the config port core, one cycle each, on I_CORE_CLK
// Notes:   Checker takes bit 0 of each valid sample per channel as its serial stream
//          Error counters saturate at full scale; the clear bit holds them at zero
//          Master power-down forces every lane-off bit high
module dac_test_decode_power_regs #(
	parameter int LANES = 8 // Serial receiver lanes
) (
	input  wire logic                                  I_CORE_CLK,      // Core clock
	input  wire logic                                  I_RST_N,         // Async reset, active low
	input  wire logic                                  i_reg_wr,        // Register write strobe
	input  wire logic                                  i_reg_rd,        // Register read strobe
	input  wire logic [11:0]                           i_reg_addr,      // Register offset
	input  wire logic [7:0]                            i_reg_wdata,     // Write data
	output logic      [7:0]                            o_reg_rdata,     // Read data
	input  wire logic                                  i_sample_valid,  // Sample strobe
	input  wire logic [15:0]                           i_sample_real,   // Real sample
	input  wire logic [15:0]                           i_sample_imag,   // Imaginary sample
	output logic      [15:0]                           o_dac_word,      // Word to converter core
	output dac_test_decode_power_pkg::shuffle_t        o_shuffle,       // Segment shuffle selects
	output dac_test_decode_power_pkg::out_format_t     o_out_format,    // Output format
	output dac_test_decode_power_pkg::port_drive_t     o_port_drive,    // Config port drive
	output logic                                       o_receiver_off,  // Receiver analog and bias off
	output logic      [LANES-1:0]                      o_lane_off       // Per-lane receiver off
);
	import dac_test_decode_power_pkg::*;

	// ****************************************************************
	// Parameter check
	// ****************************************************************
	// The lane mask register is one byte, so only eight lanes can be served
	if (LANES != 8) begin : g_lanes_check
		$error("LANES must be 8 to fit the lane mask register");
	end

	// ****************************************************************
	// Register state
	// ****************************************************************
	logic [4:0]        seq_ctrl_q;          // Inv imag, inv real, poly, clear, on
	logic [7:0]        const_high_q;        // Constant high byte
	logic [7:0]        const_low_q;         // Constant low byte
	logic              constant_test_on_q;  // Constant test enable
	logic [2:0]        shuffle_q;           // Shuffle bits
	logic [1:0]        format_q;            // Output format
	logic [3:0]        drive_q;             // Drive field
	logic              master_off_q;        // Master power-down
	logic [LANES-1:0]  lane_mask_q;         // Lane power-down mask
	logic [7:0]        err_q [2];           // Error counts, real then imag
	logic [1:0]        good_q;              // Good flags, real bit 0
	logic [14:0]       hist_q [2];          // Received bit history
	logic [3:0]        fill_q [2];          // Bits held in history
	logic              poly_seen_q;         // Polynomial in use

	// Expected next bit of the sequence from received history
	function automatic logic seq_expect(input logic [14:0] hist, input logic long_poly);
		seq_expect = long_poly ? (hist[14] ^ hist[13]) : (hist[6] ^ hist[5]);
	endfunction

	// ****************************************************************
	// Register writes
	// ****************************************************************
	// Software writes to control fields
	// Read-only counters and unmapped offsets fall to the default branch
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			seq_ctrl_q         <= RST_SEQ_CONTROL;
			const_high_q       <= RST_CONST_BYTE;
			const_low_q        <= RST_CONST_BYTE;
			constant_test_on_q <= 1'b0;
			shuffle_q          <= RST_SHUFFLE;
			format_q           <= RST_FORMAT;
			drive_q            <= RST_PORT_DRIVE;
			master_off_q       <= RST_MASTER_OFF;
			lane_mask_q        <= RST_LANE_MASK;
		end else if (i_reg_wr) begin
			case (i_reg_addr)
				ADDR_SEQ_CHECK_CONTROL: seq_ctrl_q <= i_reg_wdata[4:0];
				ADDR_CONST_VALUE_HIGH:  const_high_q <= i_reg_wdata;
				ADDR_CONST_VALUE_LOW:   const_low_q <= i_reg_wdata;
				ADDR_DIGITAL_TEST:      constant_test_on_q <= i_reg_wdata[BIT_CONST_ON];
				ADDR_SHUFFLE_CONTROL:   shuffle_q <= i_reg_wdata[2:0];
				ADDR_FORMAT_SELECT:     format_q <= i_reg_wdata[1:0];
				ADDR_PORT_DRIVE:        drive_q <= i_reg_wdata[3:0];
				ADDR_MASTER_POWERDOWN:  master_off_q <= i_reg_wdata[BIT_MASTER_OFF];
				ADDR_LANE_POWERDOWN:    lane_mask_q <= i_reg_wdata[LANES-1:0];
				default: begin
					// Unmapped offsets are ignored
				end
			endcase
		end
	end

	// ****************************************************************
	// Register reads
	// ****************************************************************
	// Read data registered one cycle after the strobe, held otherwise
	// Only a read strobe refreshes the data, so software may sample it late
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			o_reg_rdata <= 8'h00;
		end else if (i_reg_rd) begin
			case (i_reg_addr)
				ADDR_SEQ_CHECK_CONTROL: o_reg_rdata <= {good_q[1], good_q[0], 1'b0, seq_ctrl_q};
				ADDR_SEQ_ERRORS_REAL:   o_reg_rdata <= err_q[0];
				ADDR_SEQ_ERRORS_IMAG:   o_reg_rdata <= err_q[1];
				ADDR_CONST_VALUE_HIGH:  o_reg_rdata <= const_high_q;
				ADDR_CONST_VALUE_LOW:   o_reg_rdata <= const_low_q;
				ADDR_DIGITAL_TEST:      o_reg_rdata <= {6'h00, constant_test_on_q, 1'b0};
				ADDR_SHUFFLE_CONTROL:   o_reg_rdata <= {5'h00, shuffle_q};
				ADDR_FORMAT_SELECT:     o_reg_rdata <= {6'h00, format_q};
				ADDR_PORT_DRIVE:        o_reg_rdata <= {4'h0, drive_q};
				ADDR_MASTER_POWERDOWN:  o_reg_rdata <= {7'h00, master_off_q};
				ADDR_LANE_POWERDOWN:    o_reg_rdata <= lane_mask_q;
				default:                o_reg_rdata <= 8'h00; // Unmapped reads zero
			endcase
		end
	end

	// ****************************************************************
	// Sequence checker
	// ****************************************************************
	logic        seq_on;     // Checker running
	logic        seq_clear;  // Counters held clear
	logic        long_poly;  // Long sequence chosen
	logic [1:0]  rx_bit;     // Received bits after inversion
	logic [3:0]  need_fill;  // History depth before comparing
	logic [1:0]  seq_armed;  // History full, this sample is compared
	logic [1:0]  seq_miss;   // Received bit differs from expected

	// Decode checker controls and incoming bits
	always_comb begin
		seq_on    = seq_ctrl_q[BIT_SEQ_ON];
		seq_clear = seq_ctrl_q[BIT_SEQ_CLEAR];
		long_poly = seq_ctrl_q[BIT_SEQ_POLY];
		rx_bit[0] = i_sample_real[0] ^ seq_ctrl_q[BIT_SEQ_INV_REAL];
		rx_bit[1] = i_sample_imag[0] ^ seq_ctrl_q[BIT_SEQ_INV_IMAG];
		// Compare only once a whole polynomial's worth of bits is held
		need_fill = long_poly ? 4'(LONG_SEQ_LEN) : 4'(SHORT_SEQ_LEN);
	end

	// ****************************************************************
	// Per-channel compare
	// ****************************************************************
	// Qualifiers shared by good flags and counters, so the two never disagree
	always_comb begin
		for (int c = 0; c < 2; c++) begin
			seq_armed[c] = seq_on && i_sample_valid && (poly_seen_q == long_poly) && (fill_q[c] >= need_fill);
			seq_miss[c]  = rx_bit[c] != seq_expect(hist_q[c], long_poly);
		end
	end

	// History, fill and good flags; restart on disable or polynomial change
	// Disabling or swapping polynomial throws the history away
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			// Empty histories and low flags until the checker runs
			poly_seen_q <= 1'b0;
			good_q      <= 2'b00;
			for (int c = 0; c < 2; c++) begin
				hist_q[c] <= 15'h0000;
				fill_q[c] <= 4'h0;
			end
		end else begin
			poly_seen_q <= long_poly;
			for (int c = 0; c < 2; c++) begin
				if (!seq_on || poly_seen_q != long_poly) begin
					fill_q[c] <= 4'h0;
					good_q[c] <= 1'b0;
				end else if (i_sample_valid) begin
					hist_q[c] <= {hist_q[c][13:0], rx_bit[c]};
					if (fill_q[c] < need_fill) begin
						fill_q[c] <= fill_q[c] + 4'h1;
					end else begin
						good_q[c] <= !seq_miss[c];
					end
				end
			end
		end
	end

	// Error counters: saturate at full scale, clear bit wins while held
	// Counting stops at full scale rather than wrapping back to zero
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			for (int c = 0; c < 2; c++) begin
				err_q[c] <= 8'h00;
			end
		end else begin
			for (int c = 0; c < 2; c++) begin
				if (seq_clear) begin
					err_q[c] <= 8'h00;
				end else if (seq_armed[c] && seq_miss[c] && err_q[c] != 8'hff) begin
					err_q[c] <= err_q[c] + 8'h01;
				end
			end
		end
	end

	// ****************************************************************
	// Outputs to converter core, decoder, port and receiver
	// ****************************************************************
	// Data path select and registered control outputs
	// Outputs leave reset with the receiver and every lane off
	// Master off overrides the lane mask so no lane wakes while the bias is down
	always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			o_dac_word     <= 16'h0000;
			o_shuffle      <= shuffle_t'(RST_SHUFFLE);
			o_out_format   <= out_format_t'(RST_FORMAT);
			o_port_drive   <= port_drive_t'(RST_PORT_DRIVE);
			o_receiver_off <= RST_MASTER_OFF;
			o_lane_off     <= {LANES{1'b1}};
		end else begin
			o_dac_word     <= constant_test_on_q ? {const_high_q, const_low_q} : i_sample_real;
			o_shuffle.top_segment_scramble    <= shuffle_q[BIT_SHUF_TOP];
			o_shuffle.middle_segment_scramble <= shuffle_q[BIT_SHUF_MIDDLE];
			o_shuffle.fast_path_scramble      <= shuffle_q[BIT_SHUF_FAST];
			o_out_format   <= out_format_t'(format_q);
			o_port_drive   <= port_drive_t'(drive_q);
			o_receiver_off <= master_off_q;
			o_lane_off     <= lane_mask_q | {LANES{master_off_q}};
		end
	end

endmodule
